//--- hw/tws_consts.vh
// Purpose: constants of the two-wire serial controller with pin routing
// Assumes: included by bare name from the design files
// Notes: offsets are byte addresses on the plain register port
`ifndef TWS_CONSTS_VH
`define TWS_CONSTS_VH

// Register offsets
`define TWS_ADDR_CFG  8'h09
`define TWS_ADDR_CTL  8'h28
`define TWS_ADDR_DAT  8'h29

// Reset values
`define TWS_CFG_RST   8'h00
`define TWS_CTL_RST   8'h00

// Shared configuration fields
`define TWS_CFG_POS   7
`define TWS_CFG_WID1  1
`define TWS_CFG_WID0  0
`define TWS_CFG_WMASK 8'hB3

// Status and control fields
`define TWS_CTL_MSTR  7
`define TWS_CTL_CONT  6
`define TWS_CTL_XMIT  5
`define TWS_CTL_ACK   4
`define TWS_CTL_ADDR  3
`define TWS_CTL_ARB   2
`define TWS_CTL_RSTOP 1
`define TWS_CTL_EN    0

// Timing: half period of a 100 kHz serial clock
`define TWS_CLK_MHZ   200
`define TWS_HALF_NS   5000
`define TWS_HALF_CYC  ((`TWS_HALF_NS * `TWS_CLK_MHZ) / 1000)

`endif

//--- hw/tws_sync.v
// Purpose: two-stage synchroniser for asynchronous pin levels
// Assumes: inputs are levels from outside the clock domain
// Notes: only the second stage may be read by other logic
`default_nettype none

module tws_sync #(
  parameter W = 4
) (
  input  wire         clk_sys_i,
  input  wire         sys_rst_i,
  input  wire [W-1:0] async_i,
  output wire [W-1:0] sync_o
);

  reg [W-1:0] meta_r;
  reg [W-1:0] sync_r;

  genvar g;
  generate
    for (g = 0; g < W; g = g + 1)
    begin : g_bit
      always @(posedge clk_sys_i or posedge sys_rst_i)
      begin
        if (sys_rst_i)
        begin
          meta_r[g] <= 1'b1;
          sync_r[g] <= 1'b1;
        end
        else
        begin
          meta_r[g] <= async_i[g];
          sync_r[g] <= meta_r[g];
        end
      end
    end
  endgenerate

  assign sync_o = sync_r;

endmodule

`default_nettype wire

//--- hw/tws_pinmux.v
// Purpose: routes serial lines and parallel port ownership onto GP ports
// Assumes: configuration comes straight from the shared register
// Notes: all pin outputs are registered
`default_nettype none
`include "tws_consts.vh"

module tws_pinmux (
  input  wire       clk_sys_i,
  input  wire       sys_rst_i,
  input  wire [7:0] cfg_i,
  input  wire       en_i,
  input  wire       scl_drv_i,
  input  wire       sda_drv_i,
  output wire       sel_p2_o,
  output reg  [1:0] p1_tw_o,
  output reg  [1:0] p2_tw_o,
  output reg  [1:0] p1_tw_oe_o,
  output reg  [1:0] p2_tw_oe_o,
  output reg        p1_tw_od_o,
  output reg        p2_tw_od_o,
  output reg        par_p0_own_o,
  output reg        par_p1_own_o,
  output reg        par_p3_own_o,
  output reg  [3:0] par_cfg_o
);

  wire [1:0] wid = {cfg_i[`TWS_CFG_WID1], cfg_i[`TWS_CFG_WID0]};
  // Width bit 1 overrides the position bit
  assign sel_p2_o = wid[1] | cfg_i[`TWS_CFG_POS];

  wire [1:0] drv = en_i ? {sda_drv_i, scl_drv_i} : 2'b00;

  always @(posedge clk_sys_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      p1_tw_o      <= 2'b00;
      p2_tw_o      <= 2'b00;
      p1_tw_oe_o   <= 2'b00;
      p2_tw_oe_o   <= 2'b00;
      p1_tw_od_o   <= 1'b0;
      p2_tw_od_o   <= 1'b0;
      par_p0_own_o <= 1'b0;
      par_p1_own_o <= 1'b0;
      par_p3_own_o <= 1'b0;
      par_cfg_o    <= 4'h0;
    end
    else
    begin
      p1_tw_o      <= 2'b00;
      p2_tw_o      <= 2'b00;
      p1_tw_oe_o   <= sel_p2_o ? 2'b00 : drv;
      p2_tw_oe_o   <= sel_p2_o ? drv : 2'b00;
      p1_tw_od_o   <= en_i & ~sel_p2_o;
      p2_tw_od_o   <= en_i & sel_p2_o;
      par_p0_own_o <= wid != 2'b00;
      par_p1_own_o <= wid[1];
      par_p3_own_o <= wid == 2'b11;
      par_cfg_o    <= cfg_i[5:2];
    end
  end

endmodule

`default_nettype wire

//--- hw/tws_top.v
// Purpose: two-wire serial controller with shared pin routing register
// Assumes: one 200 MHz clock; registers on a plain one-cycle port
// Notes: byte engine holds the clock low while firmware responds
//
// What this block does
// - Reset clears the whole shared configuration register.
// - Nonzero port-width field activates the parallel port and takes pins.
// - Width 11 uses ports 3,1,0; 10 ports 1,0; 01 port 0; 00 off.
// - Width bit 1 puts serial pins on port 2; else position bit selects.
// - Serial clock goes to bit 0, data to bit 1 of chosen port.
// - Serial function stays inactive until its own enable bit is set.
// - Enable forces the chosen port's two low bits into open drain.
// - Config bits 5..4 serve only the parallel port, 3..2 read as 0; 7,1,0 route pins.
// - Master, slave and multi-master bus operation are supported.
// - Bus is held stalled while waiting for firmware to respond.
// - Interrupt per byte, on receive-slave stop with acknowledge set, and on lost arbitration.
// - Data address reads received byte, writes byte to transmit.
// - Status bits are valid when the interrupt is raised.
// - Serial lines are driven only by the controller when enabled.
// - Setting master role sends start then first byte from data.
// - Clearing master role sends stop; lost arbitration clears it.
// - Writing proceed starts next byte; reads busy until done.
// - Receive drives acknowledge per byte; transmit reports acknowledge.
//
// Decided for this implementation: the address-and-strobe port.
`default_nettype none
`include "tws_consts.vh"

module tws_top (
  input  wire       clk_sys_i,
  input  wire       sys_rst_i,
  input  wire [7:0] reg_addr_i,
  input  wire [7:0] reg_wdata_i,
  input  wire       reg_wr_i,
  input  wire       reg_rd_i,
  output reg  [7:0] reg_rdata_o,
  output reg        tw_irq_o,
  input  wire [1:0] p1_tw_i,
  input  wire [1:0] p2_tw_i,
  output wire [1:0] p1_tw_o,
  output wire [1:0] p2_tw_o,
  output wire [1:0] p1_tw_oe_o,
  output wire [1:0] p2_tw_oe_o,
  output wire       p1_tw_od_o,
  output wire       p2_tw_od_o,
  output wire       par_p0_own_o,
  output wire       par_p1_own_o,
  output wire       par_p3_own_o,
  output wire [3:0] par_cfg_o
);

  localparam [3:0] ST_IDLE  = 4'h0;
  localparam [3:0] ST_MSTRT = 4'h1;
  localparam [3:0] ST_MLOW  = 4'h2;
  localparam [3:0] ST_MHIGH = 4'h3;
  localparam [3:0] ST_HOLD  = 4'h4;
  localparam [3:0] ST_STOP1 = 4'h5;
  localparam [3:0] ST_STOP2 = 4'h6;
  localparam [3:0] ST_STOP3 = 4'h7;
  localparam [3:0] ST_RS1   = 4'h8;
  localparam [3:0] ST_RS2   = 4'h9;
  localparam [3:0] ST_SBITS = 4'hA;
  localparam integer HALF_I = `TWS_HALF_CYC;
  localparam [10:0] HALF    = HALF_I[10:0];

  // Released level of the data line for the current bit
  function bit_val;
    input       tx;
    input [3:0] cnt;
    input       msb;
    input       ack;
    begin
      if (cnt < 4'd8)
        bit_val = tx ? msb : 1'b1;
      else
        bit_val = tx ? 1'b1 : ~ack;
    end
  endfunction

  reg  [7:0]  cfg_r;
  reg         en_r, mstr_r, busy_r, xmit_r, ack_r, addr_r, arb_r, rstop_r;
  reg         restart_r;
  reg  [7:0]  tx_r, rx_r, shift_r;
  reg  [3:0]  state_r, bitcnt_r;
  reg  [10:0] tmr_r;
  reg         scl_drv_r, sda_drv_r, dir_r, mact_r, sact_r;
  reg         bus_busy_r, scl_q_r, sda_q_r, smp_r;
  wire [3:0]  pin_s;
  wire        sel_p2;

  tws_sync #(
    .W (4)
  ) u_sync (
    .clk_sys_i (clk_sys_i),
    .sys_rst_i (sys_rst_i),
    .async_i   ({p2_tw_i, p1_tw_i}),
    .sync_o    (pin_s)
  );

  tws_pinmux u_pinmux (
    .clk_sys_i    (clk_sys_i),
    .sys_rst_i    (sys_rst_i),
    .cfg_i        (cfg_r),
    .en_i         (en_r),
    .scl_drv_i    (scl_drv_r),
    .sda_drv_i    (sda_drv_r),
    .sel_p2_o     (sel_p2),
    .p1_tw_o      (p1_tw_o),
    .p2_tw_o      (p2_tw_o),
    .p1_tw_oe_o   (p1_tw_oe_o),
    .p2_tw_oe_o   (p2_tw_oe_o),
    .p1_tw_od_o   (p1_tw_od_o),
    .p2_tw_od_o   (p2_tw_od_o),
    .par_p0_own_o (par_p0_own_o),
    .par_p1_own_o (par_p1_own_o),
    .par_p3_own_o (par_p3_own_o),
    .par_cfg_o    (par_cfg_o)
  );

  wire scl_s   = sel_p2 ? pin_s[2] : pin_s[0];
  wire sda_s   = sel_p2 ? pin_s[3] : pin_s[1];
  wire scl_up  = scl_s & ~scl_q_r;
  wire scl_dn  = ~scl_s & scl_q_r;
  wire start_d = scl_s & scl_q_r & sda_q_r & ~sda_s;
  wire stop_d  = scl_s & scl_q_r & ~sda_q_r & sda_s;
  wire tmr_0   = tmr_r == 11'd0;
  wire wr_cfg  = reg_wr_i & (reg_addr_i == `TWS_ADDR_CFG);
  wire wr_ctl  = reg_wr_i & (reg_addr_i == `TWS_ADDR_CTL) & ~busy_r;
  wire wr_dat  = reg_wr_i & (reg_addr_i == `TWS_ADDR_DAT);
  wire go      = busy_r | ~mstr_r;
  wire [7:0] sh_in = {shift_r[6:0], sda_s};
  wire [7:0] ss_in = {shift_r[6:0], smp_r};
  wire [3:0] cnt_p = bitcnt_r + 4'd1;
  wire [7:0] ctl_v = {mstr_r, busy_r, xmit_r, ack_r,
                      addr_r, arb_r, rstop_r, en_r};

  // Register read port, data one cycle after the strobe
  always @(posedge clk_sys_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      reg_rdata_o <= 8'h00;
    else if (reg_rd_i)
    begin
      case (reg_addr_i)
        `TWS_ADDR_CFG: reg_rdata_o <= cfg_r;
        `TWS_ADDR_CTL: reg_rdata_o <= ctl_v;
        `TWS_ADDR_DAT: reg_rdata_o <= rx_r;
        default:       reg_rdata_o <= 8'h00;
      endcase
    end
    else
      reg_rdata_o <= 8'h00;
  end

  always @(posedge clk_sys_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      cfg_r <= `TWS_CFG_RST;
      tx_r  <= 8'h00;
    end
    else
    begin
      if (wr_cfg)
        cfg_r <= reg_wdata_i & `TWS_CFG_WMASK;
      if (wr_dat)
        tx_r <= reg_wdata_i;
    end
  end

  always @(posedge clk_sys_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      {mstr_r, busy_r, xmit_r, ack_r,
       addr_r, arb_r, rstop_r, en_r} <= `TWS_CTL_RST;
      restart_r  <= 1'b0;
      rx_r       <= 8'h00;
      shift_r    <= 8'h00;
      state_r    <= ST_IDLE;
      bitcnt_r   <= 4'h0;
      tmr_r      <= 11'd0;
      scl_drv_r  <= 1'b0;
      sda_drv_r  <= 1'b0;
      dir_r      <= 1'b0;
      mact_r     <= 1'b0;
      sact_r     <= 1'b0;
      bus_busy_r <= 1'b0;
      scl_q_r    <= 1'b1;
      sda_q_r    <= 1'b1;
      smp_r      <= 1'b1;
      tw_irq_o   <= 1'b0;
    end
    else
    begin
      scl_q_r  <= scl_s;
      sda_q_r  <= sda_s;
      tw_irq_o <= 1'b0;
      if (!tmr_0)
        tmr_r <= tmr_r - 11'd1;
      if (start_d)
        bus_busy_r <= 1'b1;
      else if (stop_d)
        bus_busy_r <= 1'b0;

      // Firmware writes first; hardware events below win the same cycle
      if (wr_ctl)
      begin
        en_r    <= reg_wdata_i[`TWS_CTL_EN];
        xmit_r  <= reg_wdata_i[`TWS_CTL_XMIT];
        ack_r   <= reg_wdata_i[`TWS_CTL_ACK];
        mstr_r  <= reg_wdata_i[`TWS_CTL_MSTR];
        rstop_r <= reg_wdata_i[`TWS_CTL_RSTOP];
        arb_r   <= reg_wdata_i[`TWS_CTL_ARB] & ~mstr_r;
        busy_r  <= reg_wdata_i[`TWS_CTL_CONT] |
                   (reg_wdata_i[`TWS_CTL_MSTR] & ~mstr_r);
        restart_r <= reg_wdata_i[`TWS_CTL_ARB] & mstr_r &
                     reg_wdata_i[`TWS_CTL_CONT];
        if (reg_wdata_i[`TWS_CTL_CONT])
          addr_r <= 1'b0;
      end

      if (!en_r)
      begin
        state_r   <= ST_IDLE;
        scl_drv_r <= 1'b0;
        sda_drv_r <= 1'b0;
        mact_r    <= 1'b0;
        sact_r    <= 1'b0;
      end
      else if (!mact_r && stop_d && sact_r)
      begin
        if (!dir_r && ack_r)
        begin
          rstop_r  <= 1'b1;
          tw_irq_o <= 1'b1;
          busy_r   <= 1'b0;
        end
        state_r   <= ST_IDLE;
        scl_drv_r <= 1'b0;
        sda_drv_r <= 1'b0;
        sact_r    <= 1'b0;
      end
      else if (!mact_r && start_d)
      begin
        state_r   <= ST_SBITS;
        sact_r    <= 1'b1;
        addr_r    <= 1'b1;
        dir_r     <= 1'b0;
        bitcnt_r  <= 4'h0;
        sda_drv_r <= 1'b0;
        scl_drv_r <= 1'b0;
      end
      else
      begin
        case (state_r)
          ST_IDLE:
          begin
            if (mstr_r && busy_r && !bus_busy_r)
            begin
              state_r   <= ST_MSTRT;
              mact_r    <= 1'b1;
              sda_drv_r <= 1'b1;
              tmr_r     <= HALF;
            end
          end
          ST_MSTRT:
          begin
            if (tmr_0)
            begin
              scl_drv_r <= 1'b1;
              shift_r   <= tx_r;
              dir_r     <= 1'b1;
              bitcnt_r  <= 4'h0;
              tmr_r     <= HALF;
              state_r   <= ST_MLOW;
            end
          end
          ST_MLOW:
          begin
            sda_drv_r <= ~bit_val(dir_r, bitcnt_r, shift_r[7], ack_r);
            if (tmr_0)
            begin
              scl_drv_r <= 1'b0;
              tmr_r     <= HALF;
              state_r   <= ST_MHIGH;
            end
          end
          ST_MHIGH:
          begin
            if (!scl_s)
              tmr_r <= HALF; // Clock stretched by another party
            else if (tmr_0)
            begin
              scl_drv_r <= 1'b1;
              tmr_r     <= HALF;
              state_r   <= ST_MLOW;
              if (dir_r && bitcnt_r < 4'd8 && !sda_drv_r && !sda_s)
              begin
                mstr_r    <= 1'b0;
                arb_r     <= 1'b1;
                addr_r    <= 1'b1;
                busy_r    <= 1'b0;
                tw_irq_o  <= 1'b1;
                mact_r    <= 1'b0;
                scl_drv_r <= 1'b0;
                sda_drv_r <= 1'b0;
                state_r   <= ST_IDLE;
              end
              else if (bitcnt_r < 4'd8)
              begin
                shift_r  <= sh_in;
                bitcnt_r <= cnt_p;
                if (bitcnt_r == 4'd7 && !dir_r)
                begin
                  rx_r     <= sh_in;
                  busy_r   <= 1'b0;
                  tw_irq_o <= 1'b1;
                  state_r  <= ST_HOLD;
                end
              end
              else if (dir_r)
              begin
                ack_r    <= ~sda_s;
                bitcnt_r <= 4'h0;
                busy_r   <= 1'b0;
                tw_irq_o <= 1'b1;
                state_r  <= ST_HOLD;
              end
              else
              begin
                bitcnt_r <= 4'h0;
                dir_r    <= xmit_r;
                shift_r  <= tx_r;
                state_r  <= mstr_r ? ST_MLOW : ST_STOP1;
              end
            end
          end
          ST_HOLD:
          begin
            if (!mact_r && busy_r)
            begin
              scl_drv_r <= 1'b0;
              state_r   <= ST_SBITS;
              if (bitcnt_r == 4'd8)
                sda_drv_r <= ~bit_val(dir_r, bitcnt_r, 1'b1, ack_r);
              else
              begin
                dir_r     <= xmit_r;
                shift_r   <= tx_r;
                sda_drv_r <= ~bit_val(xmit_r, 4'h0, tx_r[7], ack_r);
              end
            end
            else if (mact_r && go)
            begin
              tmr_r   <= HALF;
              state_r <= ST_MLOW;
              if (bitcnt_r == 4'd8)
                state_r <= ST_MLOW;
              else if (!mstr_r)
                state_r <= ST_STOP1;
              else if (restart_r)
              begin
                restart_r <= 1'b0;
                state_r   <= ST_RS1;
              end
              else
              begin
                dir_r   <= xmit_r;
                shift_r <= tx_r;
              end
            end
          end
          ST_STOP1:
          begin
            sda_drv_r <= 1'b1;
            if (tmr_0)
            begin
              scl_drv_r <= 1'b0;
              tmr_r     <= HALF;
              state_r   <= ST_STOP2;
            end
          end
          ST_STOP2:
          begin
            if (!scl_s)
              tmr_r <= HALF;
            else if (tmr_0)
            begin
              sda_drv_r <= 1'b0;
              tmr_r     <= HALF;
              state_r   <= ST_STOP3;
            end
          end
          ST_STOP3:
          begin
            if (tmr_0)
            begin
              mact_r  <= 1'b0;
              mstr_r  <= 1'b0;
              busy_r  <= 1'b0;
              state_r <= ST_IDLE;
            end
          end
          ST_RS1:
          begin
            sda_drv_r <= 1'b0;
            if (tmr_0)
            begin
              scl_drv_r <= 1'b0;
              tmr_r     <= HALF;
              state_r   <= ST_RS2;
            end
          end
          ST_RS2:
          begin
            if (!scl_s)
              tmr_r <= HALF;
            else if (tmr_0)
            begin
              sda_drv_r <= 1'b1;
              tmr_r     <= HALF;
              state_r   <= ST_MSTRT;
            end
          end
          ST_SBITS:
          begin
            if (scl_up)
              smp_r <= sda_s;
            if (scl_dn)
            begin
              if (bitcnt_r < 4'd8)
              begin
                shift_r  <= ss_in;
                bitcnt_r <= cnt_p;
                sda_drv_r <= ~bit_val(dir_r, cnt_p, ss_in[7], ack_r);
                if (bitcnt_r == 4'd7 && !dir_r)
                begin
                  rx_r      <= ss_in;
                  scl_drv_r <= 1'b1;
                  sda_drv_r <= 1'b0;
                  busy_r    <= 1'b0;
                  tw_irq_o  <= 1'b1;
                  state_r   <= ST_HOLD;
                end
              end
              else
              begin
                bitcnt_r  <= 4'h0;
                sda_drv_r <= 1'b0;
                if (dir_r)
                begin
                  ack_r     <= ~smp_r;
                  scl_drv_r <= 1'b1;
                  busy_r    <= 1'b0;
                  tw_irq_o  <= 1'b1;
                  state_r   <= ST_HOLD;
                end
              end
            end
          end
          default:
            state_r <= ST_IDLE;
        endcase
      end
    end
  end

endmodule

`default_nettype wire

//--- bench/tws_top_props.sv
// Purpose: pin and register port checks of the two-wire controller
// Assumes: bound to tws_top; config shadowed from register writes
// Notes: pin outputs trail the config register by one clock
`default_nettype none
module tws_top_props (
  input wire logic       clk_sys_i,
  input wire logic       sys_rst_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic       reg_wr_i,
  input wire logic       reg_rd_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic       tw_irq_o,
  input wire logic [1:0] p1_tw_o,
  input wire logic [1:0] p2_tw_o,
  input wire logic [1:0] p1_tw_oe_o,
  input wire logic [1:0] p2_tw_oe_o,
  input wire logic       p1_tw_od_o,
  input wire logic       p2_tw_od_o,
  input wire logic       par_p0_own_o,
  input wire logic       par_p1_own_o,
  input wire logic       par_p3_own_o,
  input wire logic [3:0] par_cfg_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] cfg_s;
  logic [7:0] cfg_d;
  always @(posedge clk_sys_i or posedge sys_rst_i)
    if (sys_rst_i)
    begin
      cfg_s <= 8'h00;
      cfg_d <= 8'h00;
    end
    else
    begin
      if (reg_wr_i && reg_addr_i == 8'h09)
        cfg_s <= reg_wdata_i & 8'hB3;
      cfg_d <= cfg_s;
    end
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);
  property p_cfg_rd;
    reg_rd_i && reg_addr_i == 8'h09 |=> reg_rdata_o == cfg_s;
  endproperty
  a_cfg_rd: assert property (p_cfg_rd) else $error("config read bad");
  property p_rd_idle;
    !$past(reg_rd_i) |-> reg_rdata_o == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("rdata not 0");
  property p_own0;
    par_p0_own_o == |cfg_d[1:0];
  endproperty
  a_own0: assert property (p_own0) else $error("port 0 owner wrong");
  property p_own1;
    par_p1_own_o == cfg_d[1];
  endproperty
  a_own1: assert property (p_own1) else $error("port 1 owner wrong");
  property p_own3;
    par_p3_own_o == &cfg_d[1:0];
  endproperty
  a_own3: assert property (p_own3) else $error("port 3 owner wrong");
  property p_pcfg;
    par_cfg_o == cfg_d[5:2];
  endproperty
  a_pcfg: assert property (p_pcfg) else $error("parallel cfg wrong");
  property p_od1;
    p1_tw_od_o |-> !(cfg_d[7] || cfg_d[1]);
  endproperty
  a_od1: assert property (p_od1) else $error("port 1 wrongly used");
  property p_od2;
    p2_tw_od_o |-> (cfg_d[7] || cfg_d[1]);
  endproperty
  a_od2: assert property (p_od2) else $error("port 2 wrongly used");
  property p_out0;
    p1_tw_o == 2'b00 && p2_tw_o == 2'b00;
  endproperty
  a_out0: assert property (p_out0) else $error("pin drives high");
  property p_oe_od;
    (|p1_tw_oe_o |-> p1_tw_od_o) and (|p2_tw_oe_o |-> p2_tw_od_o);
  endproperty
  a_oe_od: assert property (p_oe_od) else $error("pin pulled off");
  property p_irq;
    tw_irq_o |=> !tw_irq_o;
  endproperty
  a_irq: assert property (p_irq) else $error("irq longer than 1");
endmodule
`default_nettype wire

//--- bench/tws_slave_model.sv
// Purpose: far-side slave that receives bytes and acknowledges
// Assumes: lines pulled up; only drives data low
// Notes: nack_i withholds the acknowledge
`default_nettype none
module tws_slave_model (
  input  wire logic       clk_i,
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  input  wire logic       nack_i,
  output var  logic       sda_low_o,
  output var  logic [7:0] byte_o,
  output var  logic       stop_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       scl_q = 1'b1;
  logic       sda_q = 1'b1;
  logic [3:0] cnt_r = 4'd0;
  initial
  begin
    sda_low_o = 1'b0;
    byte_o = 8'h00;
    stop_o = 1'b0;
  end
  always @(posedge clk_i)
  begin
    scl_q <= scl_i;
    sda_q <= sda_i;
    if (scl_i && scl_q && sda_q && !sda_i)
    begin
      cnt_r <= 4'd0;
      stop_o <= 1'b0;
    end
    if (scl_i && scl_q && !sda_q && sda_i)
      stop_o <= 1'b1;
    if (scl_i && !scl_q && cnt_r < 4'd8)
    begin
      byte_o <= {byte_o[6:0], sda_i};
      cnt_r <= cnt_r + 4'd1;
    end
    if (!scl_i && scl_q && cnt_r == 4'd8)
    begin
      sda_low_o <= !nack_i;
      cnt_r <= 4'd9;
    end
    if (!scl_i && scl_q && cnt_r == 4'd9)
    begin
      sda_low_o <= 1'b0;
      cnt_r <= 4'd0;
    end
  end
endmodule
`default_nettype wire

//--- bench/testbench.sv
// Purpose: self-checking bench of the two-wire controller
// Assumes: slave model on the bus, pull-ups on both lines
// Notes: random config values from a fixed seed
`default_nettype none
`include "tws_consts.vh"
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clk_sys_i, sys_rst_i, reg_wr_i, reg_rd_i, slv_nack;
  logic [7:0] reg_addr_i, reg_wdata_i, w, b1, b2;
  wire  [7:0] reg_rdata_o, slv_byte;
  wire  [1:0] p1_tw_o, p2_tw_o, p1_tw_oe_o, p2_tw_oe_o;
  wire  [3:0] par_cfg_o;
  wire        tw_irq_o, p1_tw_od_o, p2_tw_od_o, slv_low, slv_stop;
  wire        par_p0_own_o, par_p1_own_o, par_p3_own_o, scl_w, sda_w;
  int         miscompares = 0, cmp_count = 0, cyc = 0, n;
  assign scl_w = ~(p1_tw_oe_o[0] | p2_tw_oe_o[0]);
  assign sda_w = ~(p1_tw_oe_o[1] | p2_tw_oe_o[1] | slv_low);
  tws_top dut (
    .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .tw_irq_o(tw_irq_o),
    .p1_tw_i({sda_w, scl_w}), .p2_tw_i({sda_w, scl_w}),
    .p1_tw_o(p1_tw_o), .p2_tw_o(p2_tw_o), .p1_tw_oe_o(p1_tw_oe_o),
    .p2_tw_oe_o(p2_tw_oe_o), .p1_tw_od_o(p1_tw_od_o),
    .p2_tw_od_o(p2_tw_od_o), .par_p0_own_o(par_p0_own_o),
    .par_p1_own_o(par_p1_own_o), .par_p3_own_o(par_p3_own_o),
    .par_cfg_o(par_cfg_o));
  tws_slave_model slv (.clk_i(clk_sys_i), .scl_i(scl_w), .sda_i(sda_w),
    .nack_i(slv_nack), .sda_low_o(slv_low), .byte_o(slv_byte),
    .stop_o(slv_stop));
  initial
  begin
    clk_sys_i = 1'b0;
    forever #2.5 clk_sys_i = ~clk_sys_i;
  end
  task automatic results;
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
    cmp_count++;
    if (e !== g)
    begin
      $display("FAIL %s expected %h seen %h", nm, e, g);
      miscompares++;
    end
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge clk_sys_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge clk_sys_i);
    reg_wr_i <= 1'b0;
  endtask
  task automatic rd(logic [7:0] a, logic [7:0] m, logic [7:0] e, string nm);
    @(posedge clk_sys_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge clk_sys_i);
    reg_rd_i <= 1'b0;
    #1;
    chk(nm, e, reg_rdata_o & m);
  endtask
  task automatic wait_irq;
    bit got;
    got = 1'b0;
    for (int k = 0; k < 30000 && !got; k++)
    begin
      @(posedge clk_sys_i);
      #1;
      got = (tw_irq_o === 1'b1);
    end
    chk("irq", 8'h01, {7'h00, got});
  endtask
  always @(posedge clk_sys_i)
  begin
    cyc <= cyc + 1;
    if (cyc == 95000)
    begin
      $display("FAIL run expected done seen hang");
      miscompares++;
      results();
    end
  end
  initial
  begin
    sys_rst_i = 1'b1;
    reg_addr_i = 8'h00;
    reg_wdata_i = 8'h00;
    reg_wr_i = 1'b0;
    reg_rd_i = 1'b0;
    slv_nack = 1'b0;
    repeat (16) @(posedge clk_sys_i);
    sys_rst_i <= 1'b0;
    void'($urandom(76));
    rd(`TWS_ADDR_CFG, 8'hFF, 8'h00, "cfg reset");
    rd(`TWS_ADDR_CTL, 8'hFF, 8'h00, "ctl reset");
    rd(8'h5A, 8'hFF, 8'h00, "unmapped");
    $display("test reset done");
    for (int i = 0; i < 8; i++)
    begin
      w = (8'($urandom) & 8'hFC) | 8'(i & 3);
      wr(`TWS_ADDR_CFG, w);
      rd(`TWS_ADDR_CFG, 8'hFF, w & `TWS_CFG_WMASK, "cfg");
      chk("own p0", {7'h0, |w[1:0]}, {7'h0, par_p0_own_o});
      chk("own p1", {7'h0, w[1]}, {7'h0, par_p1_own_o});
      chk("own p3", {7'h0, &w[1:0]}, {7'h0, par_p3_own_o});
      chk("par cfg", {4'h0, w[5:4], 2'b00}, {4'h0, par_cfg_o});
      chk("od off", 8'h00, {6'h0, p1_tw_od_o, p2_tw_od_o});
      wr(`TWS_ADDR_CTL, 8'h01);
      repeat (2) @(posedge clk_sys_i);
      #1;
      chk("od p1", {7'h0, ~(w[7] | w[1])}, {7'h0, p1_tw_od_o});
      chk("od p2", {7'h0, w[7] | w[1]}, {7'h0, p2_tw_od_o});
      chk("lines", 8'h00, {4'h0, p1_tw_oe_o, p2_tw_oe_o});
      wr(`TWS_ADDR_CTL, 8'h00);
    end
    $display("test routing done");
    wr(`TWS_ADDR_CFG, 8'h00);
    b1 = 8'($urandom);
    b2 = 8'($urandom);
    wr(`TWS_ADDR_DAT, b1);
    wr(`TWS_ADDR_CTL, 8'hA1);
    wait_irq();
    rd(`TWS_ADDR_CTL, 8'hFF, 8'hB1, "status ack");
    chk("byte one", b1, slv_byte);
    slv_nack <= 1'b1;
    wr(`TWS_ADDR_DAT, b2);
    wr(`TWS_ADDR_CTL, 8'hE1);
    rd(`TWS_ADDR_CTL, 8'h40, 8'h40, "busy");
    wait_irq();
    rd(`TWS_ADDR_CTL, 8'hFF, 8'hA1, "status nack");
    chk("byte two", b2, slv_byte);
    slv_nack <= 1'b0;
    b1 = ~b1;
    wr(`TWS_ADDR_DAT, b1);
    wr(`TWS_ADDR_CTL, 8'hE5);
    wait_irq();
    rd(`TWS_ADDR_CTL, 8'hFF, 8'hB1, "status restart");
    chk("byte restart", b1, slv_byte);
    wr(`TWS_ADDR_CTL, 8'hD1);
    wait_irq();
    rd(`TWS_ADDR_CTL, 8'hFF, 8'h91, "status rx");
    rd(`TWS_ADDR_DAT, 8'hFF, 8'hFF, "rx byte");
    wr(`TWS_ADDR_CTL, 8'h21);
    for (n = 0; n < 6000 && slv_stop !== 1'b1; n++)
      @(posedge clk_sys_i);
    chk("stop", 8'h01, {7'h0, slv_stop});
    $display("test master done");
    results();
  end
endmodule
bind tws_top tws_top_props u_props (
  .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .reg_addr_i(reg_addr_i),
  .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
  .reg_rdata_o(reg_rdata_o), .tw_irq_o(tw_irq_o), .p1_tw_o(p1_tw_o),
  .p2_tw_o(p2_tw_o), .p1_tw_oe_o(p1_tw_oe_o), .p2_tw_oe_o(p2_tw_oe_o),
  .p1_tw_od_o(p1_tw_od_o), .p2_tw_od_o(p2_tw_od_o),
  .par_p0_own_o(par_p0_own_o), .par_p1_own_o(par_p1_own_o),
  .par_p3_own_o(par_p3_own_o), .par_cfg_o(par_cfg_o));
`default_nettype wire
